/* File: verilog/sic_pkg.sv */
/*
 * sic_pkg: shared constants for the scan input conditioning block.
 * assumes: every design file refers to it as sic_pkg::name, never imported.
 */
`default_nettype none
package sic_pkg;
    // =====================================================
    // sizes
    localparam int NUM_IN   = 16;   // inputs 0..15, run/stop selectable
    localparam int NUM_FAST = 4;    // fast inputs are inputs 0..3
    localparam int SEL_W    = 4;    // run/stop input select width
    localparam int FLEN_W   = 8;    // filter length width
    // =====================================================
    // register byte offsets
    localparam logic [7:0] REG_FILT_EN  = 8'h00;  // per input filter enable
    localparam logic [7:0] REG_FILT_LEN = 8'h04;  // integrator length in ticks
    localparam logic [7:0] REG_FAST_CFG = 8'h08;  // fast input functions
    localparam logic [7:0] REG_RUNSTOP  = 8'h0C;  // run/stop input source
    localparam logic [7:0] REG_IMAGE    = 8'h10;  // scan image, read only
    localparam logic [7:0] REG_STATUS   = 8'h14;  // sticky events, read clears
    localparam logic [7:0] REG_MASK     = 8'h18;  // interrupt mask
    // =====================================================
    // field positions
    localparam int FC_LATCH = 0;    // latch enables [3:0]
    localparam int FC_EVENT = 4;    // event enables [7:4]
    localparam int FC_RISE  = 8;    // event rising edge [11:8]
    localparam int FC_FALL  = 12;   // event falling edge [15:12]
    localparam int FC_CNT   = 16;   // counter enables [19:16]
    localparam int FC_W     = 20;   // fast config width
    localparam int RS_EN    = 0;    // run/stop input enable
    localparam int RS_SEL   = 4;    // run/stop select [7:4]
    localparam int ST_CFG   = 4;    // status: rejected config write
    localparam int ST_W     = 5;    // status width
    // =====================================================
    // reset values
    localparam logic [15:0]       FILT_EN_RST  = 16'h0000;
    localparam logic [FLEN_W-1:0] FILT_LEN_RST = 8'h04;
    localparam logic [FC_W-1:0]   FAST_CFG_RST = 20'h00000;
    localparam logic [7:0]        RUNSTOP_RST  = 8'h00;
    localparam logic [ST_W-1:0]   MASK_RST     = 5'h00;
    // =====================================================
    // timing
    localparam int CLK_NS   = 40;                 // pclk period
    localparam int TICK_NS  = 1000;               // filter tick period
    localparam int TICK_CYC = TICK_NS / CLK_NS;   // cycles per tick
endpackage : sic_pkg
`default_nettype wire

/* File: verilog/sic_filter.sv */
/*
 * sic_filter: integrating bounce filter for one input.
 * assumes: tick is a one-cycle enable; din synchronous to pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module sic_filter #(
    parameter int CW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          tick,
    input  wire logic          en,
    input  wire logic [CW-1:0] len,
    input  wire logic          din,
    output logic               level
);
    logic [CW-1:0] cnt;         // integrator
    logic [CW-1:0] next_cnt;
    logic          next_level;

    // =====================================================
    // integrator: counts up while high, down while low
    always_comb begin
        next_cnt   = cnt;
        next_level = level;
        if (!en) begin
            // bypass: level follows the input directly
            next_cnt   = din ? len : '0;
            next_level = din;
        end else if (tick) begin
            if (din && cnt < len) begin
                next_cnt = cnt + CW'(1);
            end else if (!din && cnt != '0) begin
                next_cnt = cnt - CW'(1);
            end
            // hysteresis: change only at the ends of the range
            if (din && next_cnt >= len) begin
                next_level = 1'b1;
            end else if (!din && next_cnt == '0) begin
                next_level = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt   <= '0;
            level <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            level <= next_level;
        end
    end
endmodule : sic_filter
`default_nettype wire

/* File: verilog/sic_fast_cell.sv */
/*
 * sic_fast_cell: pulse latch and event detect for one fast input.
 * assumes: lvl is the filtered level; scan is a one-cycle scan pulse.
 */
`timescale 1ns/10ps
`default_nettype none
module sic_fast_cell (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic lvl,
    input  wire logic scan,
    input  wire logic latch_en,
    input  wire logic event_en,
    input  wire logic rise_sel,
    input  wire logic fall_sel,
    output logic      hold,
    output logic      evt
);
    logic prev;             // level one cycle ago
    logic next_hold;
    logic next_evt;
    logic rise;
    logic fall;

    // =====================================================
    // edge detect, latch and event request
    always_comb begin
        rise      = lvl && !prev;
        fall      = !lvl && prev;
        next_hold = hold;
        if (latch_en && rise) begin
            next_hold = 1'b1;           // new pulse wins over the scan clear
        end else if (scan || !latch_en) begin
            next_hold = 1'b0;
        end
        next_evt = event_en && ((rise && rise_sel) || (fall && fall_sel));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
            hold <= 1'b0;
            evt  <= 1'b0;
        end else begin
            prev <= lvl;
            hold <= next_hold;
            evt  <= next_evt;
        end
    end
endmodule : sic_fast_cell
`default_nettype wire

/* File: verilog/sic_top.sv */
/*
 * sic_top: scan input conditioning with an APB register slave.
 * assumes: din and run_switch synchronous to pclk; scan is a one-cycle
 * pulse from the scan engine at the start of each scan.
 */
`timescale 1ns/10ps
`default_nettype none
module sic_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] din,
    input  wire logic        run_switch,
    input  wire logic        scan,
    output logic [15:0]      image,
    output logic             run_cmd,
    output logic [3:0]       event_req,
    output logic             irq
);
    localparam int NI = sic_pkg::NUM_IN;
    localparam int NF = sic_pkg::NUM_FAST;

    // registers
    logic [NI-1:0]                 filt_en;    // filter enables
    logic [sic_pkg::FLEN_W-1:0]    filt_len;   // integrator length
    logic [sic_pkg::FC_W-1:0]      fast_cfg;   // fast input functions
    logic [7:0]                    runstop;    // run/stop source
    logic [sic_pkg::ST_W-1:0]      status;     // sticky events
    logic [sic_pkg::ST_W-1:0]      mask;       // interrupt mask
    logic [NI-1:0]                 next_filt_en;
    logic [sic_pkg::FLEN_W-1:0]    next_filt_len;
    logic [sic_pkg::FC_W-1:0]      next_fast_cfg;
    logic [7:0]                    next_runstop;
    logic [sic_pkg::ST_W-1:0]      next_status;
    logic [sic_pkg::ST_W-1:0]      next_mask;
    // bus answer
    logic [31:0]                   next_prdata;
    logic                          next_pready;
    logic                          next_pslverr;
    logic                          wr_done;    // write completes this edge
    logic                          rd_done;    // read completes this edge
    logic                          cfg_bad;    // rejected fast config write
    // datapath
    logic [NI-1:0]                 flt;        // filtered levels
    logic [NI-1:0]                 flt_on;     // effective filter enables
    logic [NF-1:0]                 hold;       // latched pulses
    logic [NF-1:0]                 evt;        // event pulses
    logic [NF-1:0]                 latch_en;
    logic [NF-1:0]                 event_en;
    logic [NF-1:0]                 cnt_en;
    logic [NI-1:0]                 next_image;
    logic                          next_run_cmd;
    logic                          next_irq;
    logic [7:0]                    tick_cnt;   // tick divider
    logic [7:0]                    next_tick_cnt;
    logic                          tick;

    assign latch_en = fast_cfg[sic_pkg::FC_LATCH +: NF];
    assign event_en = fast_cfg[sic_pkg::FC_EVENT +: NF];
    assign cnt_en   = fast_cfg[sic_pkg::FC_CNT +: NF];

    // =====================================================
    // filter tick divider
    always_comb begin
        tick          = (tick_cnt == 8'(sic_pkg::TICK_CYC - 1));
        next_tick_cnt = tick ? 8'h00 : tick_cnt + 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 8'h00;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    // =====================================================
    // per input filters and fast cells
    genvar gi;
    generate
        for (gi = 0; gi < NI; gi++) begin : g_in
            if (gi < NF) begin : g_fast
                // fast input filter allowed only when a function uses it
                assign flt_on[gi] = filt_en[gi] && (latch_en[gi] || event_en[gi] || cnt_en[gi]);
                sic_fast_cell u_cell (
                    .pclk     (pclk),
                    .presetn  (presetn),
                    .lvl      (flt[gi]),
                    .scan     (scan),
                    .latch_en (latch_en[gi]),
                    .event_en (event_en[gi]),
                    .rise_sel (fast_cfg[sic_pkg::FC_RISE + gi]),
                    .fall_sel (fast_cfg[sic_pkg::FC_FALL + gi]),
                    .hold     (hold[gi]),
                    .evt      (evt[gi])
                );
            end else begin : g_reg
                assign flt_on[gi] = filt_en[gi];
            end
            sic_filter #(.CW(sic_pkg::FLEN_W)) u_filt (
                .pclk    (pclk),
                .presetn (presetn),
                .tick    (tick),
                .en      (flt_on[gi]),
                .len     (filt_len),
                .din     (din[gi]),
                .level   (flt[gi])
            );
        end
    endgenerate

    // =====================================================
    // scan image, run/stop and interrupt
    always_comb begin
        next_image = image;
        if (scan) begin
            next_image = flt;
            next_image[NF-1:0] = flt[NF-1:0] | (hold & latch_en);
        end
        // one select field: only one input can be the extra source
        next_run_cmd = run_switch && (!runstop[sic_pkg::RS_EN]
                       || flt[runstop[sic_pkg::RS_SEL +: sic_pkg::SEL_W]]);
        next_irq = |(next_status & mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            image     <= 16'h0000;
            run_cmd   <= 1'b0;
            event_req <= 4'h0;
            irq       <= 1'b0;
        end else begin
            image     <= next_image;
            run_cmd   <= next_run_cmd;
            event_req <= evt;
            irq       <= next_irq;
        end
    end

    // =====================================================
    // APB slave: one wait state, then pready for one cycle
    always_comb begin
        rd_done       = psel && penable && pready && !pwrite;
        wr_done       = psel && penable && pready && pwrite;
        cfg_bad       = |(pwdata[sic_pkg::FC_LATCH +: NF] & pwdata[sic_pkg::FC_EVENT +: NF]);
        next_pready   = psel && penable && !pready;
        next_prdata   = 32'h00000000;
        next_pslverr  = 1'b0;
        next_filt_en  = filt_en;
        next_filt_len = filt_len;
        next_fast_cfg = fast_cfg;
        next_runstop  = runstop;
        next_mask     = mask;
        next_status   = status;
        if (rd_done && paddr == sic_pkg::REG_STATUS) begin
            // read clears only what it reported; a bit set after prdata was taken survives
            next_status = status & ~prdata[sic_pkg::ST_W-1:0];
        end
        if (next_pready) begin
            unique case (paddr)
                sic_pkg::REG_FILT_EN:  next_prdata = {16'h0000, filt_en};
                sic_pkg::REG_FILT_LEN: next_prdata = {24'h000000, filt_len};
                sic_pkg::REG_FAST_CFG: begin
                    next_prdata  = {12'h000, fast_cfg};
                    next_pslverr = pwrite && cfg_bad;
                end
                sic_pkg::REG_RUNSTOP:  next_prdata = {24'h000000, runstop};
                sic_pkg::REG_IMAGE:    begin
                    next_prdata  = {16'h0000, image};
                    next_pslverr = pwrite;
                end
                sic_pkg::REG_STATUS:   begin
                    next_prdata  = {27'h0000000, status};
                    next_pslverr = pwrite;
                end
                sic_pkg::REG_MASK:     next_prdata = {27'h0000000, mask};
                default:               next_pslverr = 1'b1;
            endcase
        end
        if (wr_done) begin
            unique case (paddr)
                sic_pkg::REG_FILT_EN:  next_filt_en  = pwdata[NI-1:0];
                sic_pkg::REG_FILT_LEN: next_filt_len = pwdata[sic_pkg::FLEN_W-1:0];
                sic_pkg::REG_FAST_CFG: begin
                    if (cfg_bad) begin
                        next_status[sic_pkg::ST_CFG] = 1'b1;
                    end else begin
                        next_fast_cfg = pwdata[sic_pkg::FC_W-1:0];
                    end
                end
                sic_pkg::REG_RUNSTOP:  next_runstop  = pwdata[7:0];
                sic_pkg::REG_MASK:     next_mask     = pwdata[sic_pkg::ST_W-1:0];
                default:               next_mask     = mask;
            endcase
        end
        // new events win over the read clear
        next_status[NF-1:0] = next_status[NF-1:0] | evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_en  <= sic_pkg::FILT_EN_RST;
            filt_len <= sic_pkg::FILT_LEN_RST;
            fast_cfg <= sic_pkg::FAST_CFG_RST;
            runstop  <= sic_pkg::RUNSTOP_RST;
            mask     <= sic_pkg::MASK_RST;
            status   <= '0;
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            filt_en  <= next_filt_en;
            filt_len <= next_filt_len;
            fast_cfg <= next_fast_cfg;
            runstop  <= next_runstop;
            mask     <= next_mask;
            status   <= next_status;
            prdata   <= next_prdata;
            pready   <= next_pready;
            pslverr  <= next_pslverr;
        end
    end

    // =====================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    filt_rise_a: assert property ($rose(flt[8]) |-> $past(din[8]))
        else $error("filtered input rose while raw input low");
    fast_bypass_a: assert property (!(latch_en[2] || event_en[2] || cnt_en[2])
        |=> flt[2] == $past(din[2]))
        else $error("fast filter active without a function");
    latch_show_a: assert property (scan && hold[0] && latch_en[0] |=> image[0])
        else $error("latched pulse not shown at scan");
    rise_only_a: assert property ($rose(hold[0]) |-> $past(flt[0]) && !$past(flt[0], 2))
        else $error("latch set without rising edge");
    cfg_excl_a: assert property ((latch_en & event_en) == 4'h0)
        else $error("latch and event on one input");
    event_edge_a: assert property (event_req[1] |-> $past(event_en[1], 2)
        && $past(flt[1], 2) != $past(flt[1], 3))
        else $error("event request without edge");
    run_sel_a: assert property (runstop[0] && run_switch
        && flt[runstop[7:4]] |=> run_cmd)
        else $error("selected run input ignored");
    run_only_a: assert property (!runstop[0] |=> run_cmd == $past(run_switch))
        else $error("run command differs from switch");
    scan_sample_a: assert property (scan |=> image[15] == $past(flt[15]))
        else $error("regular input not sampled at scan");
    latch_clear_a: assert property (scan && !flt[0] |=> !hold[0])
        else $error("latch not cleared after scan");
endmodule : sic_top
`default_nettype wire

/* File: verif/sic_field.sv */
/*
 * sic_field: field sensors and switches wired to the raw digital inputs.
 * assumes: levels change just after a rising pclk edge, by non-blocking assignment.
 */
`timescale 1ns/10ps
`default_nettype none
module sic_field (
    input  wire logic        pclk,
    output logic [15:0]      din
);
    // ==========================================================
    // contact levels, all open at power up
    initial din = 16'h0000;

    // move one contact to a new level and leave it there
    task set(input int idx, input logic val);
        @(posedge pclk);
        din[idx] <= val;
    endtask : set

    // short pulse of n cycles at val, then back to the other level
    task pulse(input int idx, input logic val, input int n);
        @(posedge pclk);
        din[idx] <= val;
        repeat (n) @(posedge pclk);
        din[idx] <= ~val;
    endtask : pulse
endmodule : sic_field
`default_nettype wire

/* File: verif/sic_top_tb.sv */
/*
 * sic_top_tb: self-checking bench for the scan input conditioning block.
 * assumes: sic_field plays the field side; this module is the apb master and scan engine.
 */
`timescale 1ns/10ps
`default_nettype none
module sic_top_tb;
    // ==========================================================
    // signals
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] din;
    logic        run_switch;
    logic        scan;
    logic [15:0] image;
    logic        run_cmd;
    logic [3:0]  event_req;
    logic        irq;
    int          err_count;
    int          total_checks;
    int          evcnt[4];           // event pulses seen per fast input

    sic_field fld (.pclk(pclk), .din(din));
    sic_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .din(din), .run_switch(run_switch), .scan(scan), .image(image), .run_cmd(run_cmd),
        .event_req(event_req), .irq(irq));

    // ==========================================================
    // clock, event pulse counter
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        for (int k = 0; k < 4; k++) if (event_req[k] === 1'b1) evcnt[k]++;
    end

    // ==========================================================
    // shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
        end
    endtask : check

    // one apb transfer; waits on pready, takes data at that edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check(32'h0, 32'h1, "pready timeout");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task regw(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, d, r, x);
        check({31'h0, x}, {31'h0, e}, "write pslverr");
    endtask : regw

    task regr(input logic [7:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] r;
        logic        x;
        apb(1'b0, a, 32'h0, r, x);
        check({31'h0, x}, {31'h0, ee}, "read pslverr");
        if (ee === 1'b0) check(r, e, "read data");
    endtask : regr

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // scan pulse; image is looked at once it has been updated
    task do_scan;
        @(posedge pclk) scan <= 1'b1;
        @(posedge pclk) scan <= 1'b0;
        @(posedge pclk);
        #1;
    endtask : do_scan

    // ==========================================================
    // scenarios
    task t_regs;
        regr(sic_pkg::REG_FILT_LEN, 32'h00000004, 1'b0);
        regr(sic_pkg::REG_FAST_CFG, 32'h00000000, 1'b0);
        regr(sic_pkg::REG_RUNSTOP, 32'h00000000, 1'b0);
        regr(8'h1C, 32'h0, 1'b1);
        regw(sic_pkg::REG_IMAGE, 32'h0000FFFF, 1'b1);
        $display("test regs done");
    endtask : t_regs

    task t_filter;
        regw(sic_pkg::REG_FILT_EN, 32'h00000104, 1'b0);
        // both high for under 4 ticks: only the fast input without a function gets through
        fld.set(8, 1'b1);
        fld.set(2, 1'b1);
        cyc(40);
        do_scan;
        check({31'h0, image[8]}, 32'h0, "glitch filtered");
        check({31'h0, image[2]}, 32'h1, "fast filter bypassed");
        fld.set(8, 1'b0);
        fld.set(2, 1'b0);
        cyc(150);
        // counter use on input 2 switches its filter in
        regw(sic_pkg::REG_FAST_CFG, 32'h00040000, 1'b0);
        fld.set(8, 1'b1);
        fld.set(2, 1'b1);
        cyc(40);
        do_scan;
        check({31'h0, image[2]}, 32'h0, "counter use filters");
        cyc(110);
        do_scan;
        check({31'h0, image[8]}, 32'h1, "steady high passes");
        check({31'h0, image[2]}, 32'h1, "filtered fast passes");
        fld.set(8, 1'b0);
        fld.set(2, 1'b0);
        fld.set(9, 1'b1);
        cyc(150);
        do_scan;
        check({16'h0, image}, 32'h00000200, "regular inputs sampled");
        fld.set(9, 1'b0);
        regw(sic_pkg::REG_FILT_EN, 32'h00000000, 1'b0);
        $display("test filter done");
    endtask : t_filter

    task t_latch;
        fld.pulse(0, 1'b1, 1);
        cyc(3);
        do_scan;
        check({31'h0, image[0]}, 32'h0, "no latch, pulse lost");
        regw(sic_pkg::REG_FAST_CFG, 32'h00000003, 1'b0);
        fld.pulse(0, 1'b1, 1);
        fld.set(1, 1'b1);
        cyc(3);
        do_scan;
        check({30'h0, image[1:0]}, 32'h3, "short pulse latched");
        fld.set(1, 1'b0);
        cyc(3);
        do_scan;
        check({30'h0, image[1:0]}, 32'h0, "held once, no fall");
        $display("test latch done");
    endtask : t_latch

    task t_events;
        int m;
        for (int i = 0; i < 4; i++) begin
            m = (i % 3) + 1;
            regw(sic_pkg::REG_FAST_CFG, (32'h10 << i) | (32'(m & 1) << (8 + i)) | (32'(m >> 1) << (12 + i)), 1'b0);
            evcnt[i] = 0;
            fld.set(i, 1'b1);
            cyc(5);
            fld.set(i, 1'b0);
            cyc(5);
            check(32'(evcnt[i]), 32'((m & 1) + (m >> 1)), "event count");
            check({31'h0, irq}, 32'h0, "masked event");
            regr(sic_pkg::REG_STATUS, 32'h1 << i, 1'b0);
        end
        regw(sic_pkg::REG_MASK, 32'h00000008, 1'b0);
        fld.set(3, 1'b1);
        cyc(5);
        check({31'h0, irq}, 32'h1, "unmasked event irq");
        regr(sic_pkg::REG_STATUS, 32'h00000008, 1'b0);
        cyc(2);
        check({31'h0, irq}, 32'h0, "read clears irq");
        fld.set(3, 1'b0);
        $display("test events done");
    endtask : t_events

    task t_reject;
        regw(sic_pkg::REG_MASK, 32'h00000010, 1'b0);
        regw(sic_pkg::REG_FAST_CFG, 32'h00000001, 1'b0);
        regw(sic_pkg::REG_FAST_CFG, 32'h00000011, 1'b1);
        cyc(2);
        check({31'h0, irq}, 32'h1, "reject raises irq");
        regr(sic_pkg::REG_FAST_CFG, 32'h00000001, 1'b0);
        regr(sic_pkg::REG_STATUS, 32'h00000010, 1'b0);
        regr(sic_pkg::REG_STATUS, 32'h00000000, 1'b0);
        $display("test reject done");
    endtask : t_reject

    task t_runstop;
        logic [3:0] sel;
        run_switch <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            sel = (j == 0) ? 4'h0 : 4'hF;
            regw(sic_pkg::REG_RUNSTOP, {24'h0, sel, 4'h1}, 1'b0);
            fld.set(int'(sel), 1'b1);
            cyc(3);
            check({31'h0, run_cmd}, 32'h1, "input says run");
            fld.set(int'(sel), 1'b0);
            cyc(3);
            check({31'h0, run_cmd}, 32'h0, "input says stop");
        end
        regw(sic_pkg::REG_RUNSTOP, 32'h00000000, 1'b0);
        cyc(3);
        check({31'h0, run_cmd}, 32'h1, "switch alone");
        run_switch <= 1'b0;
        cyc(3);
        check({31'h0, run_cmd}, 32'h0, "switch stop");
        $display("test runstop done");
    endtask : t_runstop

    // ==========================================================
    // verdict
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // ==========================================================
    // main sequence and watchdog
    initial begin
        err_count = 0; total_checks = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; run_switch = 1'b0; scan = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_filter;
        t_latch;
        t_events;
        t_reject;
        t_runstop;
        summarize;
    end
    initial begin
        #800000;
        err_count++;
        summarize;
    end
endmodule : sic_top_tb
`default_nettype wire
